// >>> design/sts_params.svh
`ifndef STS_PARAMS_SVH
`define STS_PARAMS_SVH

// ****************************************
// Clock and time base
// ****************************************
`define STS_CLK_HZ 25000000
`define STS_TICK_HZ 1000
`define STS_MS_PER_SEC 1000

// ****************************************
// Relay pulse, retry and lockout
// ****************************************
`define STS_PULSE_S 1
`define STS_RETRY_S 10
`define STS_MAX_TRIES 5
`define STS_FLASH_MS 250

// ****************************************
// Widths and reset levels
// ****************************************
`define STS_MS_W 20
`define STS_DLY_W 10
`define STS_TRY_W 3
`define STS_PIN_IDLE 1'b1
`define STS_RELAY_OFF 1'b1

`endif

// >>> design/sts_pkg.sv
`default_nettype none

package sts_pkg;

  typedef enum logic [3:0] {
    ST_ON_PRI,
    ST_ENG_DLY,
    ST_WAIT_GEN,
    ST_NE_DLY,
    ST_PULSE,
    ST_RETRY_WAIT,
    ST_PT_DLY,
    ST_ON_BKP,
    ST_EN_DLY,
    ST_COOL_DLY,
    ST_LOCKED
  } state_t;

  typedef enum logic [1:0] {
    MV_OPEN_PRI,
    MV_CLOSE_BKP,
    MV_OPEN_BKP,
    MV_CLOSE_PRI
  } move_t;

endpackage : sts_pkg

`default_nettype wire

// >>> design/timer_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "sts_params.svh"

interface timer_if #(parameter int MS_W = `STS_MS_W);
  logic start;
  logic [MS_W-1:0] loadMs;
  logic done;

  modport ctrl (output start, output loadMs, input done);
  modport tmr (input start, input loadMs, output done);
endinterface : timer_if

`default_nettype wire

// >>> design/delay_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "sts_params.svh"

module delay_timer #(parameter int MS_W = `STS_MS_W)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Millisecond enable
  input wire logic msTick,
  // Sequencer side
  timer_if.tmr tif
);

  logic [MS_W-1:0] remain_r;
  logic running_r;

  // A new start always wins over the countdown, but a done the old count set the cycle before still shows while start is high
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      remain_r <= '0;
      running_r <= 1'b0;
      tif.done <= 1'b0;
    end
    else
    begin
      tif.done <= 1'b0;
      if (tif.start)
      begin
        remain_r <= tif.loadMs;
        running_r <= (tif.loadMs != '0);
        tif.done <= (tif.loadMs == '0);
      end
      else if (running_r && msTick)
      begin
        remain_r <= remain_r - MS_W'(1);
        if (remain_r == MS_W'(1))
        begin
          running_r <= 1'b0;
          tif.done <= 1'b1;
        end
      end
    end
  end

endmodule : delay_timer

`default_nettype wire

// >>> design/input_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "sts_params.svh"

module input_sync #(parameter int W = 5)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Active-low pins
  input wire logic [W-1:0] pinN,
  // Synchronised, active high
  output logic [W-1:0] asserted
);

  logic [W-1:0] meta_r;
  logic [W-1:0] stable_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_r <= {W{`STS_PIN_IDLE}};
      stable_r <= {W{`STS_PIN_IDLE}};
    end
    else
    begin
      meta_r <= pinN;
      stable_r <= meta_r;
    end
  end

  assign asserted = ~stable_r;

endmodule : input_sync

`default_nettype wire

// >>> design/source_transfer_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "sts_params.svh"

module source_transfer_sequencer #(
  parameter int MS_CYCLES = `STS_CLK_HZ / `STS_TICK_HZ,
  parameter int DLY_W = `STS_DLY_W,
  parameter int MS_W = `STS_MS_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Source sensing, contacts and override, active-low pins
  input wire logic primaryOkN,
  input wire logic backupOkN,
  input wire logic primarySideAuxContactN,
  input wire logic backupSideAuxContactN,
  input wire logic overrideN,
  // Delay settings in seconds
  input wire logic [DLY_W-1:0] engineStartDelaySec,
  input wire logic [DLY_W-1:0] toBackupDelaySec,
  input wire logic [DLY_W-1:0] programmedTransitionDelaySec,
  input wire logic [DLY_W-1:0] toPrimaryDelaySec,
  input wire logic [DLY_W-1:0] engineCooldownDelaySec,
  // Transfer relays, active low
  output logic openPrimaryRelayN,
  output logic closePrimaryRelayN,
  output logic openBackupRelayN,
  output logic closeBackupRelayN,
  // Generator start contact, high while closed
  output logic genStartClosed,
  // Panel indicators
  output logic primaryAvailLed,
  output logic backupAvailLed,
  output logic primaryConnLed,
  output logic backupConnLed
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  localparam int DIV_W = $clog2(MS_CYCLES);
  localparam logic [MS_W-1:0] PULSE_MS = MS_W'(`STS_PULSE_S * `STS_MS_PER_SEC);
  localparam logic [MS_W-1:0] RETRY_MS = MS_W'(`STS_RETRY_S * `STS_MS_PER_SEC);
  localparam logic [MS_W-1:0] FLASH_MS = MS_W'(`STS_FLASH_MS);
  localparam logic [`STS_TRY_W-1:0] LAST_TRY = `STS_TRY_W'(`STS_MAX_TRIES - 1);

  function automatic logic [MS_W-1:0] secToMs(input logic [DLY_W-1:0] sec);
    secToMs = MS_W'(sec) * MS_W'(`STS_MS_PER_SEC);
  endfunction : secToMs

  // Drive bits: open primary, close primary, open backup, close backup
  function automatic logic [3:0] relayDrive(input sts_pkg::move_t mv);
    unique case (mv)
      sts_pkg::MV_OPEN_PRI: relayDrive = 4'h8;
      sts_pkg::MV_CLOSE_BKP: relayDrive = 4'h9;
      sts_pkg::MV_OPEN_BKP: relayDrive = 4'h2;
      sts_pkg::MV_CLOSE_PRI: relayDrive = 4'h6;
    endcase
  endfunction : relayDrive

  function automatic logic moveMade(input sts_pkg::move_t mv, input logic pA, input logic bA);
    unique case (mv)
      sts_pkg::MV_OPEN_PRI: moveMade = !pA;
      sts_pkg::MV_CLOSE_BKP: moveMade = bA;
      sts_pkg::MV_OPEN_BKP: moveMade = !bA;
      sts_pkg::MV_CLOSE_PRI: moveMade = pA;
    endcase
  endfunction : moveMade

  // ****************************************
  // Inputs and time base
  // ****************************************
  logic [4:0] inAsserted;
  logic priOk;
  logic bkpOk;
  logic priAux;
  logic bkpAux;
  logic ovrLevel;
  logic ovrLast_r;
  logic ovrPress;
  logic [DIV_W-1:0] div_r;
  logic msTick;

  input_sync #(.W(5)) u_input_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinN({overrideN, backupSideAuxContactN, primarySideAuxContactN, backupOkN, primaryOkN}),
    .asserted(inAsserted)
  );

  assign {ovrLevel, bkpAux, priAux, bkpOk, priOk} = inAsserted;
  assign ovrPress = ovrLevel && !ovrLast_r;
  assign msTick = (div_r == DIV_W'(MS_CYCLES - 1));

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_r <= '0;
      ovrLast_r <= 1'b0;
    end
    else
    begin
      div_r <= msTick ? '0 : div_r + DIV_W'(1);
      ovrLast_r <= ovrLevel;
    end
  end

  // ****************************************
  // Delay timer
  // ****************************************
  timer_if #(.MS_W(MS_W)) tmrBus ();
  logic tStart_r;
  logic [MS_W-1:0] tLoad_r;
  logic tDone;

  assign tmrBus.start = tStart_r;
  assign tmrBus.loadMs = tLoad_r;
  // A done left over from a count that a fresh start replaced must not end the new delay
  assign tDone = tmrBus.done && !tStart_r;

  delay_timer #(.MS_W(MS_W)) u_delay_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .msTick(msTick),
    .tif(tmrBus)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  sts_pkg::state_t state_r;
  sts_pkg::move_t move_r;
  logic [`STS_TRY_W-1:0] tries_r;
  logic failPri_r;
  logic made;

  assign made = moveMade(move_r, priAux, bkpAux);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= sts_pkg::ST_ON_PRI;
      move_r <= sts_pkg::MV_OPEN_PRI;
      tries_r <= '0;
      failPri_r <= 1'b0;
      tStart_r <= 1'b0;
      tLoad_r <= '0;
    end
    else
    begin
      tStart_r <= 1'b0;
      unique case (state_r)
        sts_pkg::ST_ON_PRI:
        begin
          if (priAux && !priOk)
          begin
            state_r <= sts_pkg::ST_ENG_DLY;
            tStart_r <= 1'b1;
            tLoad_r <= secToMs(engineStartDelaySec);
          end
          else if (bkpAux && !priAux)
          begin
            state_r <= sts_pkg::ST_ON_BKP;
          end
          else if (!priAux && !bkpAux && priOk)
          begin
            state_r <= sts_pkg::ST_PULSE;
            move_r <= sts_pkg::MV_CLOSE_PRI;
            tStart_r <= 1'b1;
            tLoad_r <= PULSE_MS;
          end
          else if (genStartClosed && priOk)
          begin
            state_r <= sts_pkg::ST_COOL_DLY;
            tStart_r <= 1'b1;
            tLoad_r <= secToMs(engineCooldownDelaySec);
          end
        end
        sts_pkg::ST_ENG_DLY:
        begin
          if (priOk)
            state_r <= sts_pkg::ST_ON_PRI;
          else if (tDone)
            state_r <= sts_pkg::ST_WAIT_GEN;
        end
        sts_pkg::ST_WAIT_GEN, sts_pkg::ST_NE_DLY:
        begin
          if (priOk)
          begin
            state_r <= sts_pkg::ST_COOL_DLY;
            tStart_r <= 1'b1;
            tLoad_r <= secToMs(engineCooldownDelaySec);
          end
          else if (state_r == sts_pkg::ST_WAIT_GEN && bkpOk)
          begin
            state_r <= sts_pkg::ST_NE_DLY;
            tStart_r <= 1'b1;
            tLoad_r <= secToMs(toBackupDelaySec);
          end
          else if (state_r == sts_pkg::ST_NE_DLY && tDone)
          begin
            state_r <= sts_pkg::ST_PULSE;
            move_r <= sts_pkg::MV_OPEN_PRI;
            tStart_r <= 1'b1;
            tLoad_r <= PULSE_MS;
          end
        end
        sts_pkg::ST_PULSE:
        begin
          if (made)
          begin
            tries_r <= '0;
            tStart_r <= 1'b1;
            unique case (move_r)
              sts_pkg::MV_OPEN_PRI, sts_pkg::MV_OPEN_BKP:
              begin
                state_r <= sts_pkg::ST_PT_DLY;
                tLoad_r <= secToMs(programmedTransitionDelaySec);
                move_r <= (move_r == sts_pkg::MV_OPEN_PRI) ? sts_pkg::MV_CLOSE_BKP
                                                           : sts_pkg::MV_CLOSE_PRI;
              end
              sts_pkg::MV_CLOSE_BKP:
              begin
                state_r <= sts_pkg::ST_ON_BKP;
                tStart_r <= 1'b0;
              end
              sts_pkg::MV_CLOSE_PRI:
              begin
                state_r <= sts_pkg::ST_COOL_DLY;
                tLoad_r <= secToMs(engineCooldownDelaySec);
              end
            endcase
          end
          else if (tDone && tries_r == LAST_TRY)
          begin
            state_r <= sts_pkg::ST_LOCKED;
            failPri_r <= (move_r == sts_pkg::MV_OPEN_PRI) || (move_r == sts_pkg::MV_CLOSE_PRI);
          end
          else if (tDone)
          begin
            state_r <= sts_pkg::ST_RETRY_WAIT;
            tries_r <= tries_r + `STS_TRY_W'(1);
            tStart_r <= 1'b1;
            tLoad_r <= RETRY_MS;
          end
        end
        sts_pkg::ST_RETRY_WAIT:
        begin
          if (tDone)
          begin
            state_r <= sts_pkg::ST_PULSE;
            tStart_r <= 1'b1;
            tLoad_r <= PULSE_MS;
          end
        end
        sts_pkg::ST_PT_DLY:
        begin
          if (tDone)
          begin
            state_r <= sts_pkg::ST_PULSE;
            tStart_r <= 1'b1;
            tLoad_r <= PULSE_MS;
          end
        end
        sts_pkg::ST_ON_BKP:
        begin
          if (priOk)
          begin
            state_r <= sts_pkg::ST_EN_DLY;
            tStart_r <= 1'b1;
            tLoad_r <= secToMs(toPrimaryDelaySec);
          end
        end
        sts_pkg::ST_EN_DLY:
        begin
          if (!priOk)
            state_r <= sts_pkg::ST_ON_BKP;
          else if (tDone)
          begin
            state_r <= sts_pkg::ST_PULSE;
            move_r <= sts_pkg::MV_OPEN_BKP;
            tStart_r <= 1'b1;
            tLoad_r <= PULSE_MS;
          end
        end
        sts_pkg::ST_COOL_DLY:
        begin
          // Primary lost again during cooldown: the generator is still running
          if (priAux && !priOk)
            state_r <= sts_pkg::ST_WAIT_GEN;
          else if (tDone)
            state_r <= sts_pkg::ST_ON_PRI;
        end
        sts_pkg::ST_LOCKED:
        begin
          if (ovrPress)
          begin
            tries_r <= '0;
            if (priAux)
              state_r <= sts_pkg::ST_ON_PRI;
            else if (bkpAux)
              state_r <= sts_pkg::ST_ON_BKP;
            else
            begin
              state_r <= sts_pkg::ST_PULSE;
              tStart_r <= 1'b1;
              tLoad_r <= PULSE_MS;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [3:0] relayN_r;
  logic flash_r;
  logic [MS_W-1:0] flashCnt_r;

  assign {openPrimaryRelayN, closePrimaryRelayN, openBackupRelayN, closeBackupRelayN} = relayN_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      relayN_r <= {4{`STS_RELAY_OFF}};
    else if (state_r == sts_pkg::ST_PULSE)
      relayN_r <= ~relayDrive(move_r);
    else
      relayN_r <= {4{`STS_RELAY_OFF}};
  end

  // Contact is held open at reset so no start is sent before the sequence asks
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      genStartClosed <= 1'b0;
    else if (state_r == sts_pkg::ST_ENG_DLY && tDone && !priOk)
      genStartClosed <= 1'b1;
    else if (state_r == sts_pkg::ST_COOL_DLY && tDone && !(priAux && !priOk))
      genStartClosed <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      flashCnt_r <= '0;
      flash_r <= 1'b0;
    end
    else if (msTick)
    begin
      flashCnt_r <= (flashCnt_r == FLASH_MS - MS_W'(1)) ? '0 : flashCnt_r + MS_W'(1);
      if (flashCnt_r == FLASH_MS - MS_W'(1))
        flash_r <= !flash_r;
    end
  end

  // Connected LEDs ignore AC sensing on purpose; a dead source still shows
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      primaryAvailLed <= 1'b0;
      backupAvailLed <= 1'b0;
      primaryConnLed <= 1'b0;
      backupConnLed <= 1'b0;
    end
    else
    begin
      primaryAvailLed <= priOk;
      backupAvailLed <= bkpOk;
      primaryConnLed <= (state_r == sts_pkg::ST_LOCKED && failPri_r) ? flash_r : priAux;
      backupConnLed <= (state_r == sts_pkg::ST_LOCKED && !failPri_r) ? flash_r : bkpAux;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  localparam int PULSE_LIMIT = MS_CYCLES * (`STS_PULSE_S * `STS_MS_PER_SEC + 1) + 4;
  int relayCyc_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || relayN_r == {4{`STS_RELAY_OFF}})
      relayCyc_r <= 0;
    else
      relayCyc_r <= relayCyc_r + 1;
  end

  sequence s_failTry;
    state_r == sts_pkg::ST_PULSE && !made && tDone;
  endsequence

  sequence s_backupMade;
    state_r == sts_pkg::ST_PULSE && move_r == sts_pkg::MV_CLOSE_BKP && bkpAux;
  endsequence

  property p_primFail;
    @(posedge ref_clk) disable iff (sys_rst)
    state_r == sts_pkg::ST_ON_PRI && priAux && !priOk |=> state_r == sts_pkg::ST_ENG_DLY && tStart_r;
  endproperty
  a_primFail: assert property (p_primFail) else $error("primary failure did not start delay");

  property p_genStart;
    @(posedge ref_clk) disable iff (sys_rst)
    state_r == sts_pkg::ST_ENG_DLY && tDone && !priOk |=> genStartClosed && state_r == sts_pkg::ST_WAIT_GEN;
  endproperty
  a_genStart: assert property (p_genStart) else $error("start contact not closed");

  property p_closeBkpDrive;
    @(posedge ref_clk) disable iff (sys_rst)
    state_r == sts_pkg::ST_PULSE && move_r == sts_pkg::MV_CLOSE_BKP |=>
      !openPrimaryRelayN && !closeBackupRelayN && openBackupRelayN && closePrimaryRelayN;
  endproperty
  a_closeBkpDrive: assert property (p_closeBkpDrive) else $error("backup close drive wrong");

  property p_backupRelease;
    @(posedge ref_clk) disable iff (sys_rst)
    s_backupMade |-> ##2 openPrimaryRelayN && closeBackupRelayN && backupConnLed;
  endproperty
  a_backupRelease: assert property (p_backupRelease) else $error("relays not released");

  property p_pulseBound;
    @(posedge ref_clk) disable iff (sys_rst)
    relayCyc_r <= PULSE_LIMIT;
  endproperty
  a_pulseBound: assert property (p_pulseBound) else $error("relay pulse too long");

  property p_retry;
    @(posedge ref_clk) disable iff (sys_rst)
    s_failTry ##0 tries_r != LAST_TRY |=>
      state_r == sts_pkg::ST_RETRY_WAIT && tStart_r && tLoad_r == RETRY_MS
      ##1 relayN_r == {4{`STS_RELAY_OFF}};
  endproperty
  a_retry: assert property (p_retry) else $error("retry wait not started");

  property p_lockout;
    @(posedge ref_clk) disable iff (sys_rst)
    s_failTry ##0 tries_r == LAST_TRY |=> state_r == sts_pkg::ST_LOCKED;
  endproperty
  a_lockout: assert property (p_lockout) else $error("no lockout after last try");

  property p_lockHold;
    @(posedge ref_clk) disable iff (sys_rst)
    state_r == sts_pkg::ST_LOCKED && !ovrPress |=> state_r == sts_pkg::ST_LOCKED && relayN_r == 4'hf;
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("lockout left without override");

  property p_connLed;
    @(posedge ref_clk) disable iff (sys_rst)
    state_r != sts_pkg::ST_LOCKED |=> primaryConnLed == $past(priAux);
  endproperty
  a_connLed: assert property (p_connLed) else $error("connected LED not from contact");

  property p_zeroDelay;
    @(posedge ref_clk) disable iff (sys_rst)
    tStart_r && tLoad_r == '0 |=> tmrBus.done;
  endproperty
  a_zeroDelay: assert property (p_zeroDelay) else $error("zero delay not immediate");

endmodule : source_transfer_sequencer

`default_nettype wire

// >>> verification/switch_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****
// Switch mechanism and generator
// ****
module switch_model
(
  // Clock
  input wire logic ref_clk,
  // Relay drive and start contact
  input wire logic openPrimaryRelayN,
  input wire logic closePrimaryRelayN,
  input wire logic openBackupRelayN,
  input wire logic closeBackupRelayN,
  input wire logic genStartClosed,
  // Mechanism control
  input wire logic stuck,
  input wire logic [7:0] moveDly,
  // Contacts and sensing, grounded when asserted
  output logic primarySideAuxContactN,
  output logic backupSideAuxContactN,
  output logic backupOkN
);
  // Position: 0 primary, 1 neutral, 2 backup
  logic [1:0] pos = 2'h0;
  logic [1:0] tgt;
  logic [7:0] cnt = 8'h00;
  logic [7:0] genCnt = 8'h00;

  always_comb
  begin
    tgt = pos;
    if (!openPrimaryRelayN && closeBackupRelayN && pos == 2'h0) tgt = 2'h1;
    if (!openPrimaryRelayN && !closeBackupRelayN && pos == 2'h1) tgt = 2'h2;
    if (!openBackupRelayN && closePrimaryRelayN && pos == 2'h2) tgt = 2'h1;
    if (!openBackupRelayN && !closePrimaryRelayN && pos == 2'h1) tgt = 2'h0;
  end

  // A jammed mechanism never moves however long the coil is held
  always @(negedge ref_clk)
  begin
    if (tgt == pos || stuck)
      cnt <= 8'h00;
    else if (cnt < moveDly)
      cnt <= cnt + 8'h01;
    else
    begin
      pos <= tgt;
      cnt <= 8'h00;
    end
    genCnt <= genStartClosed ? genCnt + {7'h00, genCnt != 8'h1f} : 8'h00;
  end

  assign primarySideAuxContactN = pos != 2'h0;
  assign backupSideAuxContactN = pos != 2'h2;
  assign backupOkN = genCnt != 8'h1f;
endmodule : switch_model

`default_nettype wire

// >>> verification/source_transfer_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module source_transfer_sequencer_tb_top;
  localparam int MS_CYC = 2;
  localparam int PULSE = 1000 * MS_CYC;
  localparam int RETRY = 10000 * MS_CYC;
  localparam int GEN = 8, OP = 7, CP = 6, OB = 5, CB = 4, PA = 3, BA = 2, PC = 1, BC = 0;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic primaryOkN = 1'b0;
  logic overrideN = 1'b1;
  logic stuck = 1'b0;
  logic [7:0] moveDly = 8'h03;
  logic [9:0] startDly = 10'h000;
  logic [9:0] coolDly = 10'h000;
  logic [9:0] toBkpDly = 10'h000;
  logic [9:0] transDly = 10'h000;
  logic [9:0] toPriDly = 10'h000;
  wire logic priAuxN, bkpAuxN, backupOkN;
  wire logic opN, cpN, obN, cbN, gen, paLed, baLed, pcLed, bcLed;
  wire logic [8:0] obs = {gen, opN, cpN, obN, cbN, paLed, baLed, pcLed, bcLed};
  int nMismatch = 0;
  int checkCount = 0;

  always #20 ref_clk = ~ref_clk;

  source_transfer_sequencer #(.MS_CYCLES(MS_CYC)) u_source_transfer_sequencer (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .primaryOkN(primaryOkN),
    .backupOkN(backupOkN), .primarySideAuxContactN(priAuxN),
    .backupSideAuxContactN(bkpAuxN), .overrideN(overrideN),
    .engineStartDelaySec(startDly), .toBackupDelaySec(toBkpDly),
    .programmedTransitionDelaySec(transDly), .toPrimaryDelaySec(toPriDly),
    .engineCooldownDelaySec(coolDly), .openPrimaryRelayN(opN),
    .closePrimaryRelayN(cpN), .openBackupRelayN(obN), .closeBackupRelayN(cbN),
    .genStartClosed(gen), .primaryAvailLed(paLed), .backupAvailLed(baLed),
    .primaryConnLed(pcLed), .backupConnLed(bcLed));

  switch_model u_switch_model (
    .ref_clk(ref_clk), .openPrimaryRelayN(opN), .closePrimaryRelayN(cpN),
    .openBackupRelayN(obN), .closeBackupRelayN(cbN), .genStartClosed(gen),
    .stuck(stuck), .moveDly(moveDly), .primarySideAuxContactN(priAuxN),
    .backupSideAuxContactN(bkpAuxN), .backupOkN(backupOkN));

  // ****
  // Checking helpers
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bounded wait on one output bit; a limit of zero checks at once
  task automatic waitBit(input string what, input int i, input logic v, input int lim,
                         output int n);
    n = 0;
    while (obs[i] !== v && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(what, {15'h0000, obs[i]}, {15'h0000, v});
  endtask : waitBit

  task automatic inRange(input string what, input int n, input int lo, input int hi);
    check(what, {15'h0000, n >= lo && n <= hi}, 16'h0001);
  endtask : inRange

  // ****
  // Scenarios
  // ****
  task automatic testReset();
    repeat (16) @(negedge ref_clk);
    check("resetIdle", {7'h00, obs}, 16'h00f0);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    check("primaryRest", {7'h00, obs}, 16'h00fa);
  endtask : testReset

  task automatic testToBackup();
    int n;
    startDly = 10'h001;
    primaryOkN = 1'b1;
    waitBit("paLed", PA, 1'b0, 10, n);
    waitBit("pcLed", PC, 1'b1, 0, n);
    waitBit("gen", GEN, 1'b1, PULSE + 20, n);
    inRange("startDelay", n, PULSE - 10, PULSE + 10);
    waitBit("baLed", BA, 1'b1, 60, n);
    waitBit("opN", OP, 1'b0, 10, n);
    waitBit("cbN", CB, 1'b1, 0, n);
    waitBit("pcLed", PC, 1'b0, 20, n);
    waitBit("cbN", CB, 1'b0, 20, n);
    waitBit("opN", OP, 1'b0, 0, n);
    waitBit("bcLed", BC, 1'b1, 20, n);
    waitBit("cbN", CB, 1'b1, 5, n);
    waitBit("opN", OP, 1'b1, 0, n);
  endtask : testToBackup

  task automatic testRetransfer();
    int n;
    coolDly = 10'h001;
    moveDly = 8'h28;
    primaryOkN = 1'b0;
    waitBit("paLed", PA, 1'b1, 10, n);
    waitBit("obN", OB, 1'b0, 10, n);
    waitBit("cpN", CP, 1'b1, 0, n);
    waitBit("bcLed", BC, 1'b0, 60, n);
    waitBit("cpN", CP, 1'b0, 20, n);
    waitBit("obN", OB, 1'b0, 0, n);
    waitBit("pcLed", PC, 1'b1, 60, n);
    waitBit("cpN", CP, 1'b1, 5, n);
    waitBit("obN", OB, 1'b1, 0, n);
    waitBit("genOff", GEN, 1'b0, PULSE + 20, n);
    inRange("cooldown", n, PULSE - 10, PULSE + 10);
    coolDly = 10'h000;
  endtask : testRetransfer

  task automatic testLockout();
    int n;
    int flips;
    int act;
    logic prev;
    stuck = 1'b1;
    startDly = 10'h000;
    primaryOkN = 1'b1;
    waitBit("gen", GEN, 1'b1, 60, n);
    for (int k = 0; k < 5; k++)
    begin
      waitBit("retryOpN", OP, 1'b0, (k == 0) ? 100 : RETRY + 20, n);
      if (k > 0)
        inRange("retryGap", n, RETRY - 10, RETRY + 10);
      waitBit("pulseEnd", OP, 1'b1, PULSE + 20, n);
      inRange("pulseLen", n, PULSE - 10, PULSE + 10);
    end
    // Long enough to see a sixth attempt if the limit were missed
    prev = pcLed;
    flips = 0;
    act = 0;
    repeat (RETRY + 100)
    begin
      @(negedge ref_clk);
      flips += int'(pcLed !== prev);
      prev = pcLed;
      act += int'(obs[7:4] !== 4'hf);
    end
    check("lockedDrive", 16'(act), 16'h0000);
    inRange("flashCount", flips, 39, 42);
    waitBit("bcLed", BC, 1'b0, 0, n);
    stuck = 1'b0;
    overrideN = 1'b0;
    repeat (5) @(negedge ref_clk);
    overrideN = 1'b1;
    waitBit("resumed", BC, 1'b1, 3000, n);
  endtask : testLockout

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : giveVerdict

  initial
  begin
    testReset();
    testToBackup();
    testRetransfer();
    testLockout();
    giveVerdict();
  end

  initial
  begin
    repeat (160000) @(posedge ref_clk);
    nMismatch++;
    giveVerdict();
  end
endmodule : source_transfer_sequencer_tb_top

`default_nettype wire
